// ===== include/usb_regs_pkg.sv
// package: register map, field layout and reset values of the common usb register block
package usb_regs_pkg;

    // ------------------------------------------------------------
    // register byte offsets (one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_TX_IRQ_FLAGS    = 8'h00;
    localparam logic [7:0] OFS_RX_IRQ_FLAGS    = 8'h04;
    localparam logic [7:0] OFS_TX_IRQ_ENABLE   = 8'h08;
    localparam logic [7:0] OFS_RX_IRQ_ENABLE   = 8'h0c;
    localparam logic [7:0] OFS_COMMON_FLAGS    = 8'h10;
    localparam logic [7:0] OFS_COMMON_ENABLE   = 8'h14;
    localparam logic [7:0] OFS_FRAME_NUMBER    = 8'h18;
    localparam logic [7:0] OFS_ENDPOINT_SELECT = 8'h1c;
    localparam logic [7:0] OFS_TEST_MODE       = 8'h20;
    localparam logic [7:0] OFS_TX_MAX_PACKET   = 8'h24;
    localparam logic [7:0] OFS_SESSION_CTRL    = 8'h28;
    localparam logic [7:0] OFS_STATUS          = 8'h2c;

    // ------------------------------------------------------------
    // field widths and masks
    // ------------------------------------------------------------
    localparam int         EP_FLAG_W         = 5;
    localparam logic [4:0] TX_EN_MASK        = 5'h1f;
    localparam logic [4:0] RX_EN_MASK        = 5'h1e;
    localparam logic [7:0] TEST_RW_MASK      = 8'hbf;
    localparam int         FRAME_W           = 11;
    localparam int         ENDPOINT_SELECT_FIELD_W           = 4;
    localparam int         MAXP_W            = 11;

    // ------------------------------------------------------------
    // common event flag positions
    // ------------------------------------------------------------
    localparam int BIT_SUPPLY_DROP  = 7;
    localparam int BIT_SESSION_REQ  = 6;
    localparam int BIT_DISCONNECT   = 5;
    localparam int BIT_CONNECT      = 4;
    localparam int BIT_FRAME_START  = 3;
    localparam int BIT_RESET_BABBLE = 2;
    localparam int BIT_RESUME       = 1;
    localparam int BIT_SUSPEND      = 0;

    // ------------------------------------------------------------
    // test mode bit positions
    // ------------------------------------------------------------
    localparam int BIT_FORCE_HOST  = 7;
    localparam int BIT_FIFO_ACCESS = 6;
    localparam int BIT_FULL_SPEED_FORCE_BIT    = 5;
    localparam int BIT_HIGH_SPEED_FORCE_BIT    = 4;
    localparam int BIT_TEST_PACKET = 3;
    localparam int BIT_TEST_K      = 2;
    localparam int BIT_TEST_J      = 1;
    localparam int BIT_SE0_NAK     = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_COMMON_ENABLE = 8'h06;
    localparam logic [4:0] RST_EP_ENABLE     = 5'h00;
    localparam logic [7:0] RST_TEST_MODE     = 8'h00;
    localparam logic [3:0] RST_ENDPOINT_SELECT_FIELD         = 4'h0;
    localparam logic [10:0] RST_MAXP         = 11'h000;
    localparam logic [10:0] RST_FRAME        = 11'h000;

    // operating speed selection
    typedef enum logic [1:0] {
        SPEED_FULL,
        SPEED_HIGH,
        SPEED_LOW
    } speed_t;

    // bus events reported by the link logic, one-cycle pulses
    typedef struct packed {
        logic supply_drop;
        logic session_req;
        logic disconnect;
        logic session_end;
        logic connect;
        logic frame_start;
        logic bus_reset;
        logic babble;
        logic resume;
        logic suspend;
    } bus_events_t;

    // test controls handed to the link logic
    typedef struct packed {
        logic   host_mode;
        speed_t speed;
        logic   fifo_copy;
        logic   test_packet;
        logic   drive_k;
        logic   drive_j;
        logic   se0_nak;
    } test_ctrl_t;

endpackage : usb_regs_pkg

// ===== rtl/usb_core_irq_test_regs.sv
// module: common interrupt, frame, index and test-mode registers of the usb controller
`timescale 1ns/10ps

// Functional notes
// - endpoint 0 and tx endpoints 1-4 interrupt only when their enable bit is one
// - rx endpoint enables at bits 4..1; bit 0 reserved and reads zero
// - reading the common flag register clears all its flags in that access
// - as a-device, bit 7 sets when supply drops during a session
// - as a-device, bit 6 sets on session request signaling
// - bit 5 sets on disconnect in host mode or session end as peripheral
// - bit 4 sets on device connection, only meaningful in host mode
// - bit 3 sets at each new frame start
// - bit 2 sets on bus reset as peripheral or babble as host
// - bit 1 sets on resume signaling while suspended
// - bit 0 sets on suspend signaling, peripheral mode only
// - each flag has a same-position enable; reset leaves only bits 2 and 1 set
// - last frame number read-only in bits 10..0, upper bits zero
// - four-bit endpoint selector picks the visible endpoint register set
// - force-host bit enters host mode per session until session clears
// - writing fifo-access bit copies ep0 tx packet to rx, then self-clears
// - force bits pick full or high speed on bus reset and forced host
// - test packet bit repeats the 53-byte packet preloaded by software
// - test bit 2 drives continuous k, bit 1 continuous j
// - test bit 0 stays high speed and naks every valid in token
// - eleven-bit max payload up to 1024 bytes, matches endpoint descriptor
module usb_core_irq_test_regs
    import usb_regs_pkg::*;
(
    // clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    // wishbone slave
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [7:0]                wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    // link side state and events (same clock)
    input  wire usb_regs_pkg::bus_events_t events_i,
    input  wire logic [4:0]                tx_ep_events_i,
    input  wire logic [4:0]                rx_ep_events_i,
    input  wire logic [10:0]               frame_value_i,
    input  wire logic                      frame_valid_i,
    input  wire logic                      a_device_i,
    input  wire logic                      host_mode_i,
    input  wire logic                      suspended_i,
    input  wire logic                      session_active_i,
    input  wire logic                      fifo_copy_done_i,
    // controls to link side
    output usb_regs_pkg::test_ctrl_t       test_ctrl_o,
    output logic [3:0]                     endpoint_select_o,
    output logic [10:0]                    max_payload_o,
    output logic                           direct_irq_mode_o,
    output logic                           irq_o
);
    import usb_regs_pkg::*;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [4:0]  tx_endpoint_irq_enable;
    logic [4:0]  rx_endpoint_irq_enable;
    logic [4:0]  tx_endpoint_irq_flags;
    logic [4:0]  rx_endpoint_irq_flags;
    logic [7:0]  common_bus_event_flags;
    logic [7:0]  common_bus_event_enable;
    logic [10:0] last_frame_value;
    logic [3:0]  endpoint_select_field;
    logic [7:0]  test_mode_control;
    logic [10:0] max_payload_field;
    logic        direct_irq_mode_bit;
    logic        forced_host;
    logic        fifo_copy_busy;

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // ------------------------------------------------------------
    // bus decode: answer one cycle after the strobe, single ack
    // ------------------------------------------------------------
    wire req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr      = req & wb_we_i;
    wire rd      = req & ~wb_we_i;
    wire hit_txe = wb_adr_i == OFS_TX_IRQ_ENABLE;
    wire hit_rxe = wb_adr_i == OFS_RX_IRQ_ENABLE;
    wire hit_txf = wb_adr_i == OFS_TX_IRQ_FLAGS;
    wire hit_rxf = wb_adr_i == OFS_RX_IRQ_FLAGS;
    wire hit_cf  = wb_adr_i == OFS_COMMON_FLAGS;
    wire hit_ce  = wb_adr_i == OFS_COMMON_ENABLE;
    wire hit_fr  = wb_adr_i == OFS_FRAME_NUMBER;
    wire hit_ix  = wb_adr_i == OFS_ENDPOINT_SELECT;
    wire hit_tm  = wb_adr_i == OFS_TEST_MODE;
    wire hit_mp  = wb_adr_i == OFS_TX_MAX_PACKET;
    wire hit_sc  = wb_adr_i == OFS_SESSION_CTRL;
    wire hit_st  = wb_adr_i == OFS_STATUS;
    wire [31:0] wr_txe = merge({27'h0, tx_endpoint_irq_enable}, wb_dat_i, wb_sel_i);
    wire [31:0] wr_rxe = merge({27'h0, rx_endpoint_irq_enable}, wb_dat_i, wb_sel_i);
    wire [31:0] wr_ce  = merge({24'h0, common_bus_event_enable}, wb_dat_i, wb_sel_i);
    wire [31:0] wr_ix  = merge({28'h0, endpoint_select_field}, wb_dat_i, wb_sel_i);
    wire [31:0] wr_tm  = merge({24'h0, test_mode_control}, wb_dat_i, wb_sel_i);
    wire [31:0] wr_mp  = merge({21'h0, max_payload_field}, wb_dat_i, wb_sel_i);
    wire [31:0] wr_sc  = merge({31'h0, direct_irq_mode_bit}, wb_dat_i, wb_sel_i);

    // ------------------------------------------------------------
    // event qualification into common flag positions
    // ------------------------------------------------------------
    wire [7:0] common_set;
    assign common_set[BIT_SUPPLY_DROP]  = events_i.supply_drop & a_device_i & session_active_i;
    assign common_set[BIT_SESSION_REQ]  = events_i.session_req & a_device_i;
    assign common_set[BIT_DISCONNECT]   = (events_i.disconnect & host_mode_i)
                                        | (events_i.session_end & ~host_mode_i);
    assign common_set[BIT_CONNECT]      = events_i.connect & host_mode_i;
    assign common_set[BIT_FRAME_START]  = events_i.frame_start;
    assign common_set[BIT_RESET_BABBLE] = (events_i.bus_reset & ~host_mode_i)
                                        | (events_i.babble & host_mode_i);
    assign common_set[BIT_RESUME]       = events_i.resume & suspended_i;
    assign common_set[BIT_SUSPEND]      = events_i.suspend & ~host_mode_i;

    // read clears every flag; a same-cycle event still survives (set wins)
    wire       clr_common   = rd & hit_cf;
    wire       clr_tx       = rd & hit_txf;
    wire       clr_rx       = rd & hit_rxf;
    wire [7:0] next_common  = (clr_common ? 8'h00 : common_bus_event_flags) | common_set;
    wire [4:0] next_txflags = (clr_tx ? 5'h00 : tx_endpoint_irq_flags) | tx_ep_events_i;
    wire [4:0] next_rxflags = (clr_rx ? 5'h00 : rx_endpoint_irq_flags) | (rx_ep_events_i & RX_EN_MASK);

    // enabled flags drive the single interrupt line
    wire irq_any = |(tx_endpoint_irq_flags & tx_endpoint_irq_enable)
                 | |(rx_endpoint_irq_flags & rx_endpoint_irq_enable)
                 | |(common_bus_event_flags & common_bus_event_enable);

    // ------------------------------------------------------------
    // test mode decode towards the link logic
    // ------------------------------------------------------------
    logic   forced_host_seen;
    wire    session_start = session_active_i & ~forced_host_seen;
    speed_t next_speed;
    assign next_speed = test_mode_control[BIT_HIGH_SPEED_FORCE_BIT] ? SPEED_HIGH :
                        test_mode_control[BIT_FULL_SPEED_FORCE_BIT] ? SPEED_FULL : SPEED_HIGH;
    wire next_forced_host = session_active_i &
                            (forced_host | (session_start & test_mode_control[BIT_FORCE_HOST]));
    wire fifo_go = wr & hit_tm & wb_sel_i[0] & wb_dat_i[BIT_FIFO_ACCESS];

    // read mux; reserved bits and unmapped offsets read zero
    wire [31:0] rd_data =
        hit_txe ? {27'h0, tx_endpoint_irq_enable} :
        hit_rxe ? {27'h0, rx_endpoint_irq_enable} :
        hit_txf ? {27'h0, tx_endpoint_irq_flags} :
        hit_rxf ? {27'h0, rx_endpoint_irq_flags} :
        hit_cf  ? {24'h0, common_bus_event_flags} :
        hit_ce  ? {24'h0, common_bus_event_enable} :
        hit_fr  ? {21'h0, last_frame_value} :
        hit_ix  ? {28'h0, endpoint_select_field} :
        hit_tm  ? {24'h0, test_mode_control & TEST_RW_MASK} :
        hit_mp  ? {21'h0, max_payload_field} :
        hit_sc  ? {31'h0, direct_irq_mode_bit} :
        hit_st  ? {29'h0, fifo_copy_busy, forced_host, host_mode_i} : 32'h0;

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= rd ? rd_data : 32'h0;
        end
    end

    // software-written configuration
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_endpoint_irq_enable  <= RST_EP_ENABLE;
            rx_endpoint_irq_enable  <= RST_EP_ENABLE;
            common_bus_event_enable <= RST_COMMON_ENABLE;
            endpoint_select_field   <= RST_ENDPOINT_SELECT_FIELD;
            max_payload_field       <= RST_MAXP;
            direct_irq_mode_bit     <= 1'b0;
        end else if (wr) begin
            if (hit_txe) tx_endpoint_irq_enable  <= wr_txe[4:0] & TX_EN_MASK;
            if (hit_rxe) rx_endpoint_irq_enable  <= wr_rxe[4:0] & RX_EN_MASK;
            if (hit_ce)  common_bus_event_enable <= wr_ce[7:0];
            if (hit_ix)  endpoint_select_field   <= wr_ix[3:0];
            if (hit_mp)  max_payload_field       <= wr_mp[10:0];
            if (hit_sc)  direct_irq_mode_bit     <= wr_sc[0];
        end
    end

    // test mode register; fifo-access bit is a self-clearing command
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            test_mode_control <= RST_TEST_MODE;
            fifo_copy_busy    <= 1'b0;
        end else begin
            if (wr & hit_tm) begin
                test_mode_control <= wr_tm[7:0] & TEST_RW_MASK;
            end
            if (fifo_go) begin
                fifo_copy_busy <= 1'b1;
            end else if (fifo_copy_done_i) begin
                fifo_copy_busy <= 1'b0;
            end
        end
    end

    // flags, frame capture and forced host tracking
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            common_bus_event_flags <= 8'h00;
            tx_endpoint_irq_flags  <= 5'h00;
            rx_endpoint_irq_flags  <= 5'h00;
            last_frame_value       <= RST_FRAME;
            forced_host            <= 1'b0;
            forced_host_seen       <= 1'b0;
        end else begin
            common_bus_event_flags <= next_common;
            tx_endpoint_irq_flags  <= next_txflags;
            rx_endpoint_irq_flags  <= next_rxflags;
            if (frame_valid_i) last_frame_value <= frame_value_i;
            forced_host      <= next_forced_host;
            forced_host_seen <= session_active_i;
        end
    end

    // registered outputs to the link logic
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            test_ctrl_o       <= '0;
            endpoint_select_o <= RST_ENDPOINT_SELECT_FIELD;
            max_payload_o     <= RST_MAXP;
            direct_irq_mode_o <= 1'b0;
            irq_o             <= 1'b0;
        end else begin
            test_ctrl_o.host_mode   <= next_forced_host;
            test_ctrl_o.speed       <= next_speed;
            test_ctrl_o.fifo_copy   <= fifo_go;
            test_ctrl_o.test_packet <= test_mode_control[BIT_TEST_PACKET];
            test_ctrl_o.drive_k     <= test_mode_control[BIT_TEST_K];
            test_ctrl_o.drive_j     <= test_mode_control[BIT_TEST_J];
            test_ctrl_o.se0_nak     <= test_mode_control[BIT_SE0_NAK];
            endpoint_select_o       <= endpoint_select_field;
            max_payload_o           <= max_payload_field;
            direct_irq_mode_o       <= direct_irq_mode_bit;
            irq_o                   <= irq_any;
        end
    end

endmodule : usb_core_irq_test_regs

// ===== verification/usb_regs_monitor.sv
// checker: handshake and read-back properties of the common usb register block
`timescale 1ns/10ps
module usb_regs_monitor
    import usb_regs_pkg::*;
(
    // clock and reset
    input wire logic                      clk_i,
    input wire logic                      rst_i,
    // wishbone
    input wire logic                      wb_cyc_i,
    input wire logic                      wb_stb_i,
    input wire logic                      wb_we_i,
    input wire logic [7:0]                wb_adr_i,
    input wire logic [31:0]               wb_dat_o,
    input wire logic                      wb_ack_o,
    // link side
    input wire logic                      session_active_i,
    input wire usb_regs_pkg::test_ctrl_t  test_ctrl_o
);
    // ------------------------------------------------------------
    // properties, all in the one clock domain
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire rd_ack = wb_ack_o && !wb_we_i;

    a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_rx_bit0_zero: assert property (rd_ack && wb_adr_i == OFS_RX_IRQ_ENABLE |-> !wb_dat_o[0])
        else $error("reserved rx enable bit reads one");
    a_frame_upper: assert property (rd_ack && wb_adr_i == OFS_FRAME_NUMBER |-> wb_dat_o[31:11] == '0)
        else $error("frame number upper bits not zero");
    a_endpoint_select_field_upper: assert property (rd_ack && wb_adr_i == OFS_ENDPOINT_SELECT |-> wb_dat_o[31:4] == '0)
        else $error("endpoint select upper bits not zero");
    a_maxp_upper: assert property (rd_ack && wb_adr_i == OFS_TX_MAX_PACKET |-> wb_dat_o[31:11] == '0)
        else $error("payload size upper bits not zero");
    a_copy_reads_zero: assert property (rd_ack && wb_adr_i == OFS_TEST_MODE |-> !wb_dat_o[6])
        else $error("copy request bit reads back one");
    a_copy_pulse: assert property (test_ctrl_o.fifo_copy |=> !test_ctrl_o.fifo_copy)
        else $error("copy request not a single pulse");
    a_host_in_session: assert property (test_ctrl_o.host_mode |-> $past(session_active_i))
        else $error("forced host outside a session");
    a_speed_legal: assert property (test_ctrl_o.speed != SPEED_LOW)
        else $error("speed neither full nor high");
endmodule : usb_regs_monitor

// ===== verification/usb_link_model.sv
// partner: behavioural usb link side feeding events and state to the register block
`timescale 1ns/10ps
module usb_link_model
    import usb_regs_pkg::*;
(
    // clock
    input  wire logic                      clk_i,
    // events and state toward the register block
    output usb_regs_pkg::bus_events_t      events_o,
    output logic [4:0]                     ep_o,
    output logic [10:0]                    frame_value_o,
    output logic                           frame_valid_o,
    output logic [3:0]                     state_o,
    // fifo copy handshake
    input  wire logic                      fifo_copy_i,
    output logic                           fifo_copy_done_o,
    output int                             copies_o
);
    logic [2:0] pend;

    // quiet bus at time zero; frame value holds a non-captured pattern outside pulses
    initial begin
        events_o = '0;
        ep_o = 5'h00;
        frame_value_o = 11'h2aa;
        frame_valid_o = 1'b0;
        state_o = 4'h0;
        fifo_copy_done_o = 1'b0;
        copies_o = 0;
        pend = 3'h0;
    end

    // level state {a_device, host, suspended, session}
    task automatic set_state(input logic [3:0] s);
        @(posedge clk_i);
        state_o <= s;
    endtask : set_state

    // one-cycle event pulse, frame capture when fval is high
    task automatic fire(input logic [9:0] ev, input logic [4:0] ep, input logic [10:0] fv, input logic fval);
        @(posedge clk_i);
        events_o <= bus_events_t'(ev);
        ep_o <= ep;
        frame_value_o <= fv;
        frame_valid_o <= fval;
        @(posedge clk_i);
        events_o <= '0;
        ep_o <= 5'h00;
        frame_value_o <= ~fv;
        frame_valid_o <= 1'b0;
    endtask : fire

    // the copy takes a few cycles on the fifo side, so busy is seen for a while
    always @(posedge clk_i) begin
        pend <= {pend[1:0], fifo_copy_i};
        fifo_copy_done_o <= pend[2];
        if (fifo_copy_i) begin
            copies_o <= copies_o + 1;
        end
    end
endmodule : usb_link_model

// ===== verification/testbench.sv
// testbench: register access sequences for the common usb register block
`timescale 1ns/10ps
module testbench;
    import usb_regs_pkg::*;
    // ------------------------------------------------------------
    // signals, tables and counters
    // ------------------------------------------------------------
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, rd;
    logic        wb_ack_o, copy_done, frame_valid, direct_irq_mode_o, irq_o;
    logic [4:0]  ep_ev;
    logic [10:0] frame_value, max_payload_o;
    logic [3:0]  state, endpoint_select_o;
    bus_events_t events;
    test_ctrl_t  test_ctrl_o;
    int          copies;
    int          fail_count = 0;
    int          n_tests = 0;
    logic [7:0]  rst_ofs [7] = '{8'h08, 8'h0c, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};
    logic [31:0] rst_val [7] = '{32'h0, 32'h0, 32'h06, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [9:0]  ev [13] = '{10'h200, 10'h100, 10'h080, 10'h040, 10'h020, 10'h010, 10'h008,
                             10'h004, 10'h002, 10'h001, 10'h001, 10'h200, 10'h002};
    logic [3:0]  lv [13] = '{4'h9, 4'h8, 4'h4, 4'h0, 4'h4, 4'h0, 4'h0, 4'h4, 4'h2, 4'h0, 4'h4, 4'h8, 4'h0};
    logic [7:0]  fl [13] = '{8'h80, 8'h40, 8'h20, 8'h20, 8'h10, 8'h08, 8'h04, 8'h04, 8'h02, 8'h01,
                             8'h00, 8'h00, 8'h00};

    always #20 clk_i = ~clk_i;

    usb_core_irq_test_regs i_usb_core_irq_test_regs (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .events_i(events), .tx_ep_events_i(ep_ev), .rx_ep_events_i(ep_ev), .frame_value_i(frame_value),
        .frame_valid_i(frame_valid), .a_device_i(state[3]), .host_mode_i(state[2]), .suspended_i(state[1]),
        .session_active_i(state[0]), .fifo_copy_done_i(copy_done), .test_ctrl_o(test_ctrl_o),
        .endpoint_select_o(endpoint_select_o), .max_payload_o(max_payload_o),
        .direct_irq_mode_o(direct_irq_mode_o), .irq_o(irq_o));

    usb_link_model i_usb_link_model (
        .clk_i(clk_i), .events_o(events), .ep_o(ep_ev), .frame_value_o(frame_value),
        .frame_valid_o(frame_valid), .state_o(state), .fifo_copy_i(test_ctrl_o.fifo_copy),
        .fifo_copy_done_o(copy_done), .copies_o(copies));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    // one classic cycle; the request stands until ack is sampled, a missing ack ends the run
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        for (n = 0; n < 16; n++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n == 16) begin
            fail_count++;
            test_done();
        end
    endtask : bus

    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
        bus(1'b0, adr, 32'h0);
        check(rd, exp);
    endtask : rdchk

    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            rdchk(rst_ofs[i], rst_val[i]);
        end
        bus(1'b1, OFS_SESSION_CTRL, 32'h1);
        // ten events under their qualifying state, the last three under a non-qualifying one, then a second read must be empty
        for (int i = 0; i < 13; i++) begin
            i_usb_link_model.set_state(lv[i]);
            i_usb_link_model.fire(ev[i], 5'h00, 11'h000, 1'b0);
            rdchk(OFS_COMMON_FLAGS, {24'h0, fl[i]});
            rdchk(OFS_COMMON_FLAGS, 32'h0);
        end
        check(32'(direct_irq_mode_o), 32'h1);
        i_usb_link_model.fire(10'h000, 5'h00, 11'h5a5, 1'b1);
        bus(1'b1, OFS_FRAME_NUMBER, 32'hffff);
        rdchk(OFS_FRAME_NUMBER, 32'h5a5);
        // endpoint events stay silent until enabled, reads clear them
        i_usb_link_model.fire(10'h000, 5'h11, 11'h000, 1'b0);
        repeat (3) @(posedge clk_i);
        check(32'(irq_o), 32'h0);
        bus(1'b1, OFS_TX_IRQ_ENABLE, 32'h10);
        repeat (3) @(posedge clk_i);
        check(32'(irq_o), 32'h1);
        rdchk(OFS_TX_IRQ_FLAGS, 32'h11);
        repeat (3) @(posedge clk_i);
        check(32'(irq_o), 32'h0);
        bus(1'b1, OFS_RX_IRQ_ENABLE, 32'hffff);
        rdchk(OFS_RX_IRQ_ENABLE, 32'h1e);
        check(32'(irq_o), 32'h1);
        rdchk(OFS_RX_IRQ_FLAGS, 32'h10);
        bus(1'b1, OFS_COMMON_ENABLE, 32'h08);
        rdchk(OFS_COMMON_ENABLE, 32'h08);
        i_usb_link_model.fire(10'h010, 5'h00, 11'h000, 1'b0);
        repeat (3) @(posedge clk_i);
        check(32'(irq_o), 32'h1);
        bus(1'b1, OFS_ENDPOINT_SELECT, 32'hff);
        rdchk(OFS_ENDPOINT_SELECT, 32'hf);
        check(32'(endpoint_select_o), 32'hf);
        bus(1'b1, OFS_TX_MAX_PACKET, 32'hffff);
        rdchk(OFS_TX_MAX_PACKET, 32'h7ff);
        check(32'(max_payload_o), 32'h7ff);
        bus(1'b1, 8'h80, 32'hffffffff);
        rdchk(8'h80, 32'h0);
        bus(1'b1, OFS_TEST_MODE, 32'hff);
        rdchk(OFS_STATUS, 32'h4);
        rdchk(OFS_TEST_MODE, 32'hbf);
        check(32'(test_ctrl_o), {24'h0, 1'b0, SPEED_HIGH, 5'h0f});
        check(32'(copies), 32'h1);
        i_usb_link_model.set_state(4'h1);
        repeat (3) @(posedge clk_i);
        check(32'(test_ctrl_o.host_mode), 32'h1);
        rdchk(OFS_STATUS, 32'h2);
        i_usb_link_model.set_state(4'h0);
        repeat (3) @(posedge clk_i);
        check(32'(test_ctrl_o.host_mode), 32'h0);
        bus(1'b1, OFS_TEST_MODE, 32'h20);
        repeat (2) @(posedge clk_i);
        check(32'(test_ctrl_o), {24'h0, 1'b0, SPEED_FULL, 5'h00});
        test_done();
    end

    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        test_done();
    end
endmodule : testbench

// checker sees only the ports of the register block
bind usb_core_irq_test_regs usb_regs_monitor i_usb_regs_monitor (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .session_active_i(session_active_i),
    .test_ctrl_o(test_ctrl_o));
